// ==== sim/vbm_lane_ctrl_checker.sv ====
// Checker for takeover order, bus timer and lane use of the lane controller
`timescale 1ns/100ps
module vbm_lane_ctrl_checker
  import vbm_pkg::*;
#(parameter int TIMEOUT_CYC = VBM_TIMEOUT_CYC) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched ports
  input wire logic done,
  input vbm_rsp_t rsp,
  input vbm_bus_in_t bus_in,
  input vbm_bus_out_t bus_out,
  input wire logic ctl_oe_n,
  input wire logic [3:0] data_oe_n
);
  logic [15:0] drv_q;
  wire dsl_w = !(bus_out.ds0_n && bus_out.ds1_n) && !bus_out.write_n;
  // Length of the current data strobe, so the bus timer window can be judged
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) drv_q <= '0;
    else drv_q <= (bus_out.ds0_n && bus_out.ds1_n) ? '0 : drv_q + 16'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  grant_first_a: assert property ($fell(ctl_oe_n) |-> $past(bus_in.grant, 3))
    else $error("bus driven before grant");
  bus_idle_a: assert property ($fell(ctl_oe_n) |-> $past(bus_in.as_n, 3))
    else $error("bus driven while strobe low");
  as_gap_a: assert property ($fell(bus_out.as_n) |-> $past(bus_in.as_n, 4))
    else $error("strobe high time too short");
  as_setup_a: assert property ($fell(bus_out.as_n) |-> bus_out.iack_n && !$past(ctl_oe_n, 4)
    && $past(bus_out.addr, 4) == bus_out.addr)
    else $error("address set-up too short");
  timeout_win_a: assert property (done && rsp.timeout |-> drv_q >= TIMEOUT_CYC)
    else $error("timeout too early");
  timeout_max_a: assert property (drv_q <= 2 * TIMEOUT_CYC)
    else $error("timeout too late");
  quad_lanes_a: assert property (dsl_w && !bus_out.lword_n |-> data_oe_n == 4'h0)
    else $error("quad lanes not driven");
  half_lanes_a: assert property (!bus_out.ds0_n && !bus_out.ds1_n && !bus_out.write_n
    |-> data_oe_n[1:0] == 2'h0)
    else $error("low lanes not driven");
  byte_lane_a: assert property (dsl_w && (bus_out.ds0_n != bus_out.ds1_n)
    |-> !data_oe_n[bus_out.ds0_n])
    else $error("byte lane not driven");
  cover property (done && rsp.timeout);
  cover property ($fell(bus_out.as_n));
  cover property (dsl_w && bus_out.ds0_n);
  cover property (done && rsp.berr);
endmodule // vbm_lane_ctrl_checker
bind vbm_lane_ctrl vbm_lane_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.mclk(mclk),
  .rstn(rstn), .done(done), .rsp(rsp), .bus_in(bus_in), .bus_out(bus_out),
  .ctl_oe_n(ctl_oe_n), .data_oe_n(data_oe_n));

// ==== sim/vbm_lane_ctrl_tb.sv ====
// Self-checking bench for the backplane master lane controller
`timescale 1ns/100ps
module vbm_lane_ctrl_tb
  import vbm_pkg::*;
;
  localparam logic [31:0] RD = 32'hC3A55A3C;
  logic mclk = 0, rstn = 0, req_valid = 0, feed_valid = 1, mute = 0, err = 0;
  logic [3:0] slow = 0;
  logic [31:0] feed_data = 0;
  vbm_req_t req = '0;
  logic req_ready, feed_ready, rd_valid, done, bus_req, ctl_oe_n;
  logic [3:0] data_oe_n;
  logic [31:0] wr_q;
  logic [31:0] rq[$];
  vbm_rsp_t rsp;
  vbm_bus_in_t bus_in;
  vbm_bus_out_t bus_out;
  int fails = 0, total_checks = 0, cyc = 0, nfeed = 0;
  vbm_lane_ctrl #(.TIMEOUT_CYC(50)) DUT (.mclk(mclk), .rstn(rstn), .ce(1'b1),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .feed_ready(feed_ready),
    .feed_valid(feed_valid), .feed_data(feed_data), .rd_valid(rd_valid), .done(done),
    .rsp(rsp), .bus_req(bus_req), .bus_in(bus_in), .bus_out(bus_out),
    .ctl_oe_n(ctl_oe_n), .data_oe_n(data_oe_n));
  vbm_slave_model u_slave (.mclk(mclk), .rstn(rstn), .slow(slow), .mute(mute), .err(err),
    .bus_req(bus_req), .bus_out(bus_out), .ctl_oe_n(ctl_oe_n), .data_oe_n(data_oe_n),
    .bus_in(bus_in), .wr_q(wr_q));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input vbm_size_t sz, input logic b, m, w, input logic [31:0] a,
    input logic [7:0] n);
    rq = {};
    nfeed = 0;
    req = '{sz, b, m, w, a, 6'h0D, n, feed_data};
    req_valid = 1;
    @(posedge mclk);
    #1 req_valid = 0;
    chk("request taken", {bus_req, req_ready}, 2'h2);
    for (int k = 0; k < 2000 && !done; k++) begin
      @(posedge mclk);
      #1 if (rd_valid) rq.push_back(rsp.rdata);
      if (feed_ready) nfeed++;
    end
    chk("transfer done", done, 1);
    @(posedge mclk);
    #1 chk("bus released", {ctl_oe_n, data_oe_n}, 5'h1F);
  endtask
  task automatic t_quad_blk;
    feed_data = 32'h12345678;
    fork
      xfer(VBM_SZ32, 1, 0, 1, 32'h100, 2);
      begin
        @(posedge mclk);
        #1 feed_data = 32'hA5C3E10F;
      end
    join
    chk("quad block write", wr_q, 32'hA5C3E10F);
    chk("quad block feeds", nfeed, 1);
    $display("quad block write end");
  endtask
  task automatic t_half_blk;
    slow = 3;
    xfer(VBM_SZ16, 1, 0, 0, 32'h200, 2);
    slow = 0;
    chk("half block beats", rq.size(), 2);
    chk("half block data", rq[1] & 32'hFFFF, RD & 32'hFFFF);
    $display("half block read end");
  endtask
  task automatic t_byte_blk;
    logic [7:0] ex[3] = '{8'h3C, 8'h5A, 8'h3C};
    xfer(VBM_SZ8, 1, 0, 0, 32'h301, 3);
    for (int i = 0; i < 3; i++) chk("byte block", rq[i] & 32'hFF, {24'h0, ex[i]});
    $display("byte block read end");
  endtask
  task automatic t_rmw(input vbm_size_t sz, input logic [31:0] a, msk, input int sh);
    feed_data = 32'h9E6B2D71;
    xfer(sz, 0, 1, 1, a, 1);
    chk("rmw feeds", nfeed, 1);
    chk("rmw read", rq[0] & (msk >> sh), (RD & msk) >> sh);
    chk("rmw write", wr_q & msk, (feed_data << sh) & msk);
    $display("rmw at %h end", a);
  endtask
  task automatic t_timeout;
    mute = 1;
    xfer(VBM_SZ32, 0, 0, 0, 32'h400, 1);
    mute = 0;
    chk("timeout flag", rsp.timeout, 1);
    chk("timeout no data", rq.size(), 0);
    $display("timeout end");
  endtask
  task automatic t_berr;
    err = 1;
    xfer(VBM_SZ16, 1, 0, 0, 32'h500, 3);
    err = 0;
    chk("error flag", rsp.berr, 1);
    chk("error beats", rq.size(), 1);
    $display("bus error end");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1 rstn = 1;
    repeat (3) @(posedge mclk);
    #1;
    t_quad_blk;
    t_half_blk;
    t_byte_blk;
    t_rmw(VBM_SZ8, 32'h2, 32'hFF00, 8);
    t_rmw(VBM_SZ8, 32'h3, 32'hFF, 0);
    t_rmw(VBM_SZ16, 32'h0, 32'hFFFF, 0);
    t_rmw(VBM_SZ32, 32'h0, 32'hFFFFFFFF, 0);
    t_timeout;
    t_berr;
    stop_test;
  end
endmodule // vbm_lane_ctrl_tb

// ==== sim/vbm_slave_model.sv ====
// Behavioural slave, previous owner and arbiter on the backplane
`timescale 1ns/100ps
module vbm_slave_model
  import vbm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Scenario knobs
  input wire logic [3:0] slow,
  input wire logic mute,
  input wire logic err,
  // Master side
  input wire logic bus_req,
  input vbm_bus_out_t bus_out,
  input wire logic ctl_oe_n,
  input wire logic [3:0] data_oe_n,
  output vbm_bus_in_t bus_in,
  output logic [31:0] wr_q
);
  localparam logic [31:0] RD = 32'hC3A55A3C;
  logic gnt_q, oth_n_q, oe_q, ack_q;
  logic [3:0] dly_q;
  logic [31:0] pat_q, dat_w;
  wire dsl_w = !ctl_oe_n && !(bus_out.ds0_n && bus_out.ds1_n);
  wire [3:0] sl_w = !bus_out.lword_n ? 4'hF : {2'h0, !bus_out.ds1_n, !bus_out.ds0_n};
  // Lanes D00-D31 that nobody drives show a moving pattern, or the read word RD on a lane a read selects
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dat_w[8*i+:8] = !data_oe_n[i] ? bus_out.data[8*i+:8] :
        (dsl_w && bus_out.write_n && sl_w[i]) ? RD[8*i+:8] : pat_q[8*i+:8];
    end
  end
  assign bus_in = '{oth_n_q & (ctl_oe_n | bus_out.as_n), !(ack_q && !err), !(ack_q && err),
    gnt_q, dat_w};
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {gnt_q, oth_n_q, oe_q, ack_q, dly_q, pat_q, wr_q} <= {4'h6, 4'h0, 64'h0};
    end else begin
      pat_q <= ~pat_q + 32'h01010101;
      oe_q <= ctl_oe_n;
      oth_n_q <= !(bus_req && !gnt_q);
      if (bus_req) gnt_q <= 1'b1;
      else if (ctl_oe_n && !oe_q) gnt_q <= 1'b0;
      dly_q <= dsl_w ? dly_q + 4'h1 : 4'h0;
      ack_q <= dsl_w && !mute && (dly_q >= slow || ack_q);
      if (dsl_w && !bus_out.write_n) wr_q <= dat_w;
    end
  end
endmodule // vbm_slave_model

// ==== verilog/vbm_lane_ctrl.sv ====
// Backplane bus master: bus takeover sequencing and data-lane selection
//
// Contract
// RULE1 - Double-byte blocks use low sixteen lines; quad-byte blocks use all thirty-two.
// RULE2 - Single-byte RMW: bytes 0,2 on D08-D15, bytes 1,3 on D00-D07.
// RULE3 - Double-byte RMW uses the low sixteen lines in both phases.
// RULE4 - Quad-byte RMW carries valid data on all thirty-two lines, both phases.
// RULE5 - Single-byte block beats alternate lanes, starting at the first byte's lane.
// RULE6 - Drive nothing until the previous master lets the address strobe rise.
// RULE7 - Keep every bus output undriven until our requester is granted.
// RULE8 - Wait a minimum time after address strobe rises before asserting it.
// RULE9 - Assert address strobe only after address lines met the set-up time.
// RULE10 - Bus timeout fires no earlier than T and no later than 2T.
`timescale 1ns/100ps
module vbm_lane_ctrl
  import vbm_pkg::*;
#(
  parameter int TIMEOUT_CYC = VBM_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // User request
  input wire logic req_valid,
  input vbm_req_t req,
  output logic req_ready,
  // Next write word for block beats and RMW write phase
  output logic feed_ready,
  input wire logic feed_valid,
  input wire logic [31:0] feed_data,
  // User answers
  output logic rd_valid,
  output logic done,
  output vbm_rsp_t rsp,
  // Arbitration
  output logic bus_req,
  // Backplane pins
  input vbm_bus_in_t bus_in,
  output vbm_bus_out_t bus_out,
  output logic ctl_oe_n,
  output logic [3:0] data_oe_n
);
  typedef enum {ST_IDLE, ST_GRANT, ST_ASWAIT, ST_SETUP, ST_STROBE, ST_REL, ST_FEED,
    ST_DSET, ST_FINISH} vbm_state_t;

  vbm_state_t st_q, st_d;
  vbm_req_t req_q;
  vbm_bus_in_t meta_q, sync_q;
  vbm_bus_out_t pins_q, pins_d;
  vbm_rsp_t rsp_q;
  logic ctl_oe_n_q;
  logic [3:0] data_oe_n_q;
  logic [VBM_CNT_W-1:0] cnt_q;
  logic [31:0] tmo_q;
  logic [1:0] byte_q;
  logic [7:0] left_q;
  logic [31:0] wd_q;
  logic wphase_q;
  logic rd_valid_q, done_q;

  // Decoding of the current beat
  wire logic acked = !sync_q.dtack_n || !sync_q.berr_n;
  wire logic ack_clear = sync_q.dtack_n && sync_q.berr_n;
  wire logic odd_byte = byte_q[0];
  wire logic last_beat = (left_q == 8'h01);
  wire logic tmo_hit = (tmo_q == 32'(TIMEOUT_CYC - 1));
  wire logic cnt_as_done = (cnt_q == VBM_CNT_W'(VBM_AS_HIGH_CYC - 1));
  wire logic cnt_su_done = (cnt_q == VBM_CNT_W'(VBM_SETUP_CYC - 1));
  wire logic more_phase = req_q.rmw && !wphase_q;
  // RULE1 lane select
  // RULE2 byte lanes
  // RULE3 low-half RMW
  // RULE4 full-width RMW
  wire logic [3:0] lanes = (req_q.size == VBM_SZ8) ? (odd_byte ? VBM_LANE_LO8 : VBM_LANE_HI8) :
    (req_q.size == VBM_SZ16) ? VBM_LANE_LO16 : VBM_LANE_ALL;
  wire logic [31:0] wd_lane = (req_q.size == VBM_SZ8) ?
    (odd_byte ? {24'h000000, wd_q[7:0]} : {16'h0000, wd_q[7:0], 8'h00}) :
    (req_q.size == VBM_SZ16) ? {16'h0000, wd_q[15:0]} : wd_q;
  wire logic [31:0] rd_lane = (req_q.size == VBM_SZ8) ?
    (odd_byte ? {24'h000000, sync_q.data[7:0]} : {24'h000000, sync_q.data[15:8]}) :
    (req_q.size == VBM_SZ16) ? {16'h0000, sync_q.data[15:0]} : sync_q.data;
  wire logic wr_now = req_q.write && (!req_q.rmw || wphase_q);
  wire logic as_low = (st_q == ST_STROBE) || (st_q == ST_REL) || (st_q == ST_FEED) ||
    (st_q == ST_DSET);
  // RULE6 no drive before strobe high
  // RULE7 no drive before grant
  wire logic ctl_drive = as_low || (st_q == ST_SETUP) || (st_q == ST_FINISH);
  wire logic data_drive = ctl_drive && wr_now && (st_q != ST_FINISH);
  wire logic ds_low = (st_q == ST_STROBE);

  assign req_ready = (st_q == ST_IDLE);
  assign feed_ready = (st_q == ST_FEED);
  assign bus_req = (st_q == ST_GRANT);
  assign bus_out = pins_q;
  assign ctl_oe_n = ctl_oe_n_q;
  assign data_oe_n = data_oe_n_q;
  assign rd_valid = rd_valid_q;
  assign done = done_q;
  assign rsp = rsp_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (req_valid) st_d = ST_GRANT;
      ST_GRANT: if (sync_q.grant) st_d = ST_ASWAIT;
      // RULE8 strobe high time
      ST_ASWAIT: if (sync_q.as_n && cnt_as_done) st_d = ST_SETUP;
      // RULE9 address set-up
      ST_SETUP: if (cnt_su_done) st_d = ST_STROBE;
      // RULE10 bus timer
      ST_STROBE: if (acked) st_d = ST_REL;
        else if (tmo_hit) st_d = ST_FINISH;
      // Wait for the slave to let go of its acknowledge before the next strobe
      ST_REL: begin
        if (!ack_clear) st_d = ST_REL;
        else if (!rsp_q.berr && (more_phase || (!req_q.rmw && !last_beat)))
          st_d = (req_q.write) ? ST_FEED : ST_DSET;
        else st_d = ST_FINISH;
      end
      ST_FEED: if (feed_valid) st_d = ST_DSET;
      ST_DSET: if (cnt_su_done) st_d = ST_STROBE;
      // One cycle with the strobe high and control lines still driven, then release
      ST_FINISH: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_comb begin
    pins_d = '1;
    pins_d.as_n = !as_low;
    // Interrupt acknowledge stays high: this master runs data cycles only
    pins_d.iack_n = 1'b1;
    pins_d.write_n = !wr_now;
    pins_d.lword_n = (req_q.size != VBM_SZ32);
    pins_d.addr = req_q.addr[31:1];
    pins_d.am = req_q.am;
    pins_d.ds1_n = !(ds_low && (req_q.size != VBM_SZ8 || !odd_byte));
    pins_d.ds0_n = !(ds_low && (req_q.size != VBM_SZ8 || odd_byte));
    pins_d.data = wd_lane;
  end

  // Second flop alone reads the first; all pin inputs are asynchronous
  // Grant rests low in reset, so an early request still waits for the arbiter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= VBM_BUS_IN_IDLE;
      sync_q <= VBM_BUS_IN_IDLE;
    end else if (ce) begin
      meta_q <= bus_in;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins_q <= '1;
      ctl_oe_n_q <= 1'b1;
      data_oe_n_q <= 4'hF;
    end else if (ce) begin
      pins_q <= pins_d;
      ctl_oe_n_q <= !ctl_drive;
      data_oe_n_q <= data_drive ? ~lanes : 4'hF;
    end
  end

  // Counts restart on every state change
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tmo_q <= '0;
    end else if (ce) begin
      cnt_q <= (st_d != st_q || (st_q == ST_ASWAIT && !sync_q.as_n)) ? '0 :
        cnt_q + VBM_CNT_W'(1);
      tmo_q <= (st_q == ST_STROBE && st_d == ST_STROBE) ? tmo_q + 32'h00000001 : '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      req_q <= '0;
      byte_q <= 2'h0;
      left_q <= 8'h00;
      wd_q <= '0;
      wphase_q <= 1'b0;
      rsp_q <= '0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      rd_valid_q <= 1'b0;
      done_q <= (st_q == ST_FINISH);
      if (st_q == ST_IDLE && req_valid) begin
        req_q <= req;
        byte_q <= req.addr[1:0];
        left_q <= (req.blk && !req.rmw && req.beats != 8'h00) ? req.beats : 8'h01;
        wd_q <= req.wdata;
        wphase_q <= 1'b0;
        rsp_q <= '0;
      end
      if (st_q == ST_STROBE && acked) begin
        rsp_q.berr <= !sync_q.berr_n;
        if (!wr_now) begin
          rsp_q.rdata <= rd_lane;
          rd_valid_q <= 1'b1;
        end
      end
      if (st_q == ST_STROBE && !acked && tmo_hit) rsp_q.timeout <= 1'b1;
      if (st_q == ST_REL && ack_clear) begin
        if (more_phase) begin
          wphase_q <= 1'b1;
        end else begin
          left_q <= left_q - 8'h01;
          // RULE5 alternate byte lane
          if (req_q.blk && req_q.size == VBM_SZ8) byte_q[0] <= !byte_q[0];
        end
      end
      if (st_q == ST_FEED && feed_valid) wd_q <= feed_data;
    end
  end
endmodule // vbm_lane_ctrl

// ==== verilog/vbm_pkg.sv ====
// Constants, timing counts and carrier types of the backplane master lane controller
package vbm_pkg;
  localparam int VBM_CLK_NS = 10;
  // Strobe high time before a new master may pull the address strobe low
  localparam int VBM_AS_HIGH_NS = 40;
  localparam int VBM_AS_HIGH_CYC = (VBM_AS_HIGH_NS + VBM_CLK_NS - 1) / VBM_CLK_NS;
  // Address, modifier, longword and acknowledge-high set-up before the address strobe
  localparam int VBM_SETUP_NS = 35;
  localparam int VBM_SETUP_CYC = (VBM_SETUP_NS + VBM_CLK_NS - 1) / VBM_CLK_NS;
  // Bus timer value T in microseconds
  localparam int VBM_TIMEOUT_US = 64;
  localparam int VBM_TIMEOUT_CYC = VBM_TIMEOUT_US * 1000 / VBM_CLK_NS;
  localparam int VBM_CNT_W = 16;
  // Byte-lane masks, bit 3 is D24-D31 and bit 0 is D00-D07
  localparam logic [3:0] VBM_LANE_HI8 = 4'h2;
  localparam logic [3:0] VBM_LANE_LO8 = 4'h1;
  localparam logic [3:0] VBM_LANE_LO16 = 4'h3;
  localparam logic [3:0] VBM_LANE_ALL = 4'hF;

  typedef enum logic [1:0] {VBM_SZ8, VBM_SZ16, VBM_SZ32} vbm_size_t;

  typedef struct packed {
    vbm_size_t size;
    logic blk;
    logic rmw;
    logic write;
    logic [31:0] addr;
    logic [5:0] am;
    logic [7:0] beats;
    logic [31:0] wdata;
  } vbm_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic berr;
    logic timeout;
  } vbm_rsp_t;

  typedef struct packed {
    logic as_n;
    logic ds0_n;
    logic ds1_n;
    logic write_n;
    logic iack_n;
    logic lword_n;
    logic [30:0] addr;
    logic [5:0] am;
    logic [31:0] data;
  } vbm_bus_out_t;

  typedef struct packed {
    logic as_n;
    logic dtack_n;
    logic berr_n;
    logic grant;
    logic [31:0] data;
  } vbm_bus_in_t;

  // Inactive pin levels held by the input synchroniser in reset
  localparam vbm_bus_in_t VBM_BUS_IN_IDLE = '{as_n: 1'b1, dtack_n: 1'b1, berr_n: 1'b1,
    grant: 1'b0, data: 32'h00000000};
endpackage
